// ==== tmrwo_top.sv ====
// Top of the 8-bit timer: counter, overflow, channels and pin drive
//
// Overview of operation
// - Reset clears both compare output bits
// - Nonzero output mode overrides the port value
// - Port direction bit still controls pin drive
// - Output mode zero: no action on match
// - New mode acts at next match; non-PWM force immediate
// - Counting depends only on waveform mode
// - Normal mode counts up, wraps FF to 00
// - Normal overflow flag set as counter hits zero
// - Normal mode accepts counter writes anytime
// - Clear-on-match clears counter at compare A
// - Clear-on-match sets compare flag A each period
// - Clear-on-match compare A unbuffered, may wrap
// - Clear-on-match toggle halves the match rate
// - Clear-on-match overflow set at FF to 00
// - Fast PWM modes 3 and 7, top select
// - Fast PWM clears counter tick after top
// - Fast PWM mode 2 non-inverting, 3 inverting
// - Fast PWM overflow flag set at top
// - Fast PWM toggle only on A with high bit
// - Fast PWM extreme compare values spike or constant
// - Fast PWM buffers compare values
// - Buffered compare value loads at top
// - Match sets flag next tick; write-one clears
// - Force updates bit in non-PWM modes only, no flag, no counter
// - Counter write blocks matches for next tick
`timescale 1ns/1ps
`default_nettype none

module tmrwo_top import tmrwo_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic tick_in,
  input wire logic [2:0] waveform_gen_mode_in,
  input wire logic [1:0] compare_output_mode_a_in,
  input wire logic [1:0] compare_output_mode_b_in,
  input wire logic cnt_wr_in,
  input wire logic [7:0] cnt_wdata_in,
  input wire logic cmp_a_wr_in,
  input wire logic cmp_b_wr_in,
  input wire logic [7:0] cmp_wdata_in,
  input wire logic force_a_in,
  input wire logic force_b_in,
  input wire logic ovf_clr_in,
  input wire logic flag_a_clr_in,
  input wire logic flag_b_clr_in,
  input wire logic [1:0] port_val_in,
  input wire logic [1:0] port_dir_in,
  output logic [7:0] counter_value_out,
  output logic [7:0] compare_value_a_out,
  output logic [7:0] compare_value_b_out,
  output logic overflow_flag_out,
  output logic compare_flag_a_out,
  output logic compare_flag_b_out,
  output logic compare_output_bit_a_out,
  output logic compare_output_bit_b_out,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe_out
);

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  logic is_clr_match;  // Clear-on-match mode
  logic is_fast;       // Either fast PWM mode
  logic top_is_cmp_a;  // Top comes from compare value A
  logic [7:0] top;     // Current top of count
  logic [7:0] work_a;  // Working compare value A
  logic [7:0] work_b;  // Working compare value B

  // Only the waveform mode shapes the count
  always_comb begin
    is_clr_match = (waveform_gen_mode_in == MODE_CLR_MATCH);
    is_fast = (waveform_gen_mode_in == MODE_FAST_MAX) ||
              (waveform_gen_mode_in == MODE_FAST_OCR);
    top_is_cmp_a = is_clr_match || (waveform_gen_mode_in == MODE_FAST_OCR);
    top = top_is_cmp_a ? work_a : CNT_MAX;
  end

  // ---------------------------------------------------------------
  // Counter state
  // ---------------------------------------------------------------
  tmrwo_top_s st;       // Registered counter state
  tmrwo_top_s next_st;  // Next counter state
  tmrwo_tim_s tim;      // Timing view for both channels

  // Timing view; unused mode codes run like normal mode
  always_comb begin
    tim.tick = tick_in;
    tim.at_top = (st.count == top);
    tim.blocked = st.block;
    tim.fast = is_fast;
    tim.wave_hi = waveform_gen_mode_in[2];
    tim.count = st.count;
  end

  // Counter, overflow flag and match block
  always_comb begin
    next_st = st;
    // Software write has priority over any count or clear
    if (cnt_wr_in) begin
      next_st.count = cnt_wdata_in;
    end else if (tick_in) begin
      if ((is_clr_match || is_fast) && tim.at_top) begin
        next_st.count = CNT_BOTTOM;
      end else begin
        next_st.count = st.count + CNT_STEP;
      end
    end
    // Clear first so a same-cycle set wins
    if (ovf_clr_in) begin
      next_st.ovf = 1'b0;
    end
    if (tick_in && !cnt_wr_in) begin
      if (is_fast) begin
        if (tim.at_top) begin
          next_st.ovf = 1'b1;
        end
      end else if (st.count == CNT_MAX) begin
        next_st.ovf = 1'b1;
      end
    end
    // Block stays up while the timer clock is stopped
    if (cnt_wr_in) begin
      next_st.block = 1'b1;
    end else if (tick_in) begin
      next_st.block = 1'b0;
    end
  end

  // Register, frozen while the clock enable is low
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st <= '{count: RST_COUNT, ovf: RST_BIT, block: RST_BIT};
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  assign counter_value_out = st.count;
  assign overflow_flag_out = st.ovf;

  // ---------------------------------------------------------------
  // Compare channels
  // ---------------------------------------------------------------
  // Channel A owns top in modes 2 and 7 and may toggle in fast PWM
  tmrwo_chan #(
    .HAS_TOGGLE(1'b1)
  ) u_chan_a (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .tim_in(tim),
    .mode_in(compare_output_mode_a_in),
    .cmp_wr_in(cmp_a_wr_in),
    .cmp_wdata_in(cmp_wdata_in),
    .force_in(force_a_in),
    .flag_clr_in(flag_a_clr_in),
    .cmp_work_out(work_a),
    .flag_out(compare_flag_a_out),
    .bit_out(compare_output_bit_a_out)
  );

  // Channel B has no fast PWM toggle option
  tmrwo_chan #(
    .HAS_TOGGLE(1'b0)
  ) u_chan_b (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .tim_in(tim),
    .mode_in(compare_output_mode_b_in),
    .cmp_wr_in(cmp_b_wr_in),
    .cmp_wdata_in(cmp_wdata_in),
    .force_in(force_b_in),
    .flag_clr_in(flag_b_clr_in),
    .cmp_work_out(work_b),
    .flag_out(compare_flag_b_out),
    .bit_out(compare_output_bit_b_out)
  );

  assign compare_value_a_out = work_a;
  assign compare_value_b_out = work_b;

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  tmrwo_pin u_pin_a (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .mode_in(compare_output_mode_a_in),
    .obit_in(compare_output_bit_a_out),
    .port_val_in(port_val_in[0]),
    .port_dir_in(port_dir_in[0]),
    .pin_out(pin_out[0]),
    .pin_oe_out(pin_oe_out[0])
  );

  tmrwo_pin u_pin_b (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .mode_in(compare_output_mode_b_in),
    .obit_in(compare_output_bit_b_out),
    .port_val_in(port_val_in[1]),
    .port_dir_in(port_dir_in[1]),
    .pin_out(pin_out[1]),
    .pin_oe_out(pin_oe_out[1])
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  a_reset_bit_low: assert property (disable iff (1'b0) srst_in |=>
    !compare_output_bit_a_out && !compare_output_bit_b_out)
    else $error("output bit not cleared by reset");

  a_override_pin_a: assert property (clk_en_in && compare_output_mode_a_in != COM_OFF
    |=> pin_out[0] == $past(compare_output_bit_a_out))
    else $error("pin A not driven from output bit");

  a_dir_pin_b: assert property (clk_en_in |=> pin_oe_out[1] == $past(port_dir_in[1]))
    else $error("pin B enable not from direction bit");

  a_off_no_act: assert property (clk_en_in && compare_output_mode_b_in == COM_OFF
    |=> $stable(compare_output_bit_b_out))
    else $error("output bit B moved with mode off");

  a_normal_wrap: assert property (clk_en_in && tick_in && !cnt_wr_in &&
    waveform_gen_mode_in == MODE_NORMAL && st.count == CNT_MAX
    |=> st.count == CNT_BOTTOM && overflow_flag_out)
    else $error("normal wrap or overflow wrong");

  a_match_clear: assert property (clk_en_in && tick_in && !cnt_wr_in && is_clr_match &&
    st.count == work_a |=> st.count == CNT_BOTTOM)
    else $error("clear-on-match did not clear");

  a_match_flag: assert property (clk_en_in && tick_in && !st.block &&
    st.count == work_a |=> compare_flag_a_out)
    else $error("match did not set flag A");

  a_write_block: assert property (clk_en_in && cnt_wr_in ##1
    (clk_en_in && tick_in && !compare_flag_a_out && !flag_a_clr_in) |=> !compare_flag_a_out)
    else $error("match not blocked after counter write");

  a_fast_wrap: assert property (clk_en_in && tick_in && !cnt_wr_in && is_fast &&
    st.count == top |=> st.count == CNT_BOTTOM && overflow_flag_out)
    else $error("fast PWM top handling wrong");

  a_buf_hold: assert property (clk_en_in && is_fast && cmp_a_wr_in &&
    !(tick_in && tim.at_top) |=> work_a == $past(work_a))
    else $error("buffered compare A updated early");

  a_force_flag: assert property (clk_en_in && force_b_in && !is_fast && !compare_flag_b_out &&
    !(tick_in && !st.block && st.count == work_b) |=> !compare_flag_b_out)
    else $error("force set compare flag B");

  // Clear-on-match overflow when the count passes the maximum
  a_match_overflow: assert property (clk_en_in && tick_in && !cnt_wr_in && is_clr_match &&
    st.count == CNT_MAX |=> overflow_flag_out)
    else $error("clear-on-match overflow not set");

  // Clear-on-match raises flag A at every top
  a_top_flag_a: assert property (clk_en_in && tick_in && is_clr_match && !st.block &&
    st.count == work_a |=> compare_flag_a_out)
    else $error("flag A not raised at top");

  // Normal mode only ever steps the count up by one
  a_normal_count: assert property (clk_en_in && tick_in && !cnt_wr_in &&
    waveform_gen_mode_in == MODE_NORMAL |=> counter_value_out == $past(counter_value_out) + CNT_STEP)
    else $error("normal mode count did not step");

  // Overflow flag is sticky until its clear strobe
  a_ovf_sticky: assert property (clk_en_in && overflow_flag_out && !ovf_clr_in |=> overflow_flag_out)
    else $error("overflow flag lost without clear");

  // Fast PWM bottom action on channel A, non-inverting
  a_fast_set_bottom: assert property (clk_en_in && tick_in && is_fast && tim.at_top &&
    compare_output_mode_a_in == COM_CLEAR |=> compare_output_bit_a_out)
    else $error("bit A not set at bottom");

  // Fast PWM bottom action on channel A, inverting
  a_fast_clr_bottom: assert property (clk_en_in && tick_in && is_fast && tim.at_top &&
    compare_output_mode_a_in == COM_SET |=> !compare_output_bit_a_out)
    else $error("bit A not cleared at bottom");

  // Channel B has no toggle option in fast PWM
  a_no_toggle_b: assert property (clk_en_in && is_fast && compare_output_mode_b_in == COM_TOGGLE
    |=> $stable(compare_output_bit_b_out))
    else $error("bit B toggled in fast PWM");

  // Force acts on the bit at once in non-PWM modes
  a_force_set_b: assert property (clk_en_in && force_b_in && !is_fast &&
    compare_output_mode_b_in == COM_SET |=> compare_output_bit_b_out)
    else $error("force did not set bit B");

endmodule : tmrwo_top

`default_nettype wire

// ==== tmrwo_pkg.sv ====
// Constants, carrier and state types for the 8-bit waveform timer
package tmrwo_pkg;

  // ---------------------------------------------------------------
  // Waveform generation mode values
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_FAST_OCR = 3'h7;

  // ---------------------------------------------------------------
  // Compare output mode values
  // ---------------------------------------------------------------
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // ---------------------------------------------------------------
  // Count limits and values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic RST_BIT = 1'b0;

  // ---------------------------------------------------------------
  // Timing view shared with each compare channel
  // ---------------------------------------------------------------
  typedef struct packed {
    logic tick;
    logic at_top;
    logic blocked;
    logic fast;
    logic wave_hi;
    logic [7:0] count;
  } tmrwo_tim_s;

  // Counter state of the top level
  typedef struct packed {
    logic [7:0] count;
    logic ovf;
    logic block;
  } tmrwo_top_s;

  // Compare channel state
  typedef struct packed {
    logic [7:0] hold;
    logic [7:0] work;
    logic flag;
    logic obit;
  } tmrwo_chan_s;

  // Pin driver state
  typedef struct packed {
    logic level;
    logic oe;
  } tmrwo_pin_s;

endpackage : tmrwo_pkg

// ==== tmrwo_chan.sv ====
// One compare channel: compare value buffer, compare flag, output bit
`timescale 1ns/1ps
`default_nettype none

module tmrwo_chan import tmrwo_pkg::*; #(
  parameter bit HAS_TOGGLE = 1'b0  // Fast PWM toggle option present
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire tmrwo_tim_s tim_in,
  input wire logic [1:0] mode_in,
  input wire logic cmp_wr_in,
  input wire logic [7:0] cmp_wdata_in,
  input wire logic force_in,
  input wire logic flag_clr_in,
  output logic [7:0] cmp_work_out,
  output logic flag_out,
  output logic bit_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  tmrwo_chan_s st;       // Registered state
  tmrwo_chan_s next_st;  // Next state
  logic hit;             // Real compare match this cycle
  logic bottom;          // Counter wraps to bottom this cycle

  // Next state logic
  always_comb begin
    next_st = st;
    hit = tim_in.tick && (tim_in.count == st.work) && !tim_in.blocked;
    bottom = tim_in.tick && tim_in.at_top;
    // Buffered in fast PWM, direct otherwise
    if (cmp_wr_in) begin
      next_st.hold = cmp_wdata_in;
      if (!tim_in.fast) begin
        next_st.work = cmp_wdata_in;
      end
    end
    if (tim_in.fast && bottom) begin
      next_st.work = st.hold;
    end
    // Set beats clear so no match is lost
    if (flag_clr_in) begin
      next_st.flag = 1'b0;
    end
    if (hit) begin
      next_st.flag = 1'b1;
    end
    // Output bit; mode is read live so a new mode acts at next match
    if (tim_in.fast) begin
      if (bottom && mode_in[1]) begin
        next_st.obit = (mode_in == COM_CLEAR);
      end else if (hit) begin
        unique case (mode_in)
          COM_OFF: ;
          COM_TOGGLE: if (HAS_TOGGLE && tim_in.wave_hi) next_st.obit = ~st.obit;
          COM_CLEAR: next_st.obit = 1'b0;
          COM_SET: next_st.obit = 1'b1;
        endcase
      end
    end else if (hit || force_in) begin
      // Force acts only here and touches neither flag nor counter
      unique case (mode_in)
        COM_OFF: ;
        COM_TOGGLE: next_st.obit = ~st.obit;
        COM_CLEAR: next_st.obit = 1'b0;
        COM_SET: next_st.obit = 1'b1;
      endcase
    end
  end

  // Register, frozen while the clock enable is low
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st <= '{hold: RST_CMP, work: RST_CMP, flag: RST_BIT, obit: RST_BIT};
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  assign cmp_work_out = st.work;
  assign flag_out = st.flag;
  assign bit_out = st.obit;

endmodule : tmrwo_chan

`default_nettype wire

// ==== tmrwo_pin.sv ====
// Port pin driver with compare output override
`timescale 1ns/1ps
`default_nettype none

module tmrwo_pin import tmrwo_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic [1:0] mode_in,
  input wire logic obit_in,
  input wire logic port_val_in,
  input wire logic port_dir_in,
  output logic pin_out,
  output logic pin_oe_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  tmrwo_pin_s st;       // Registered pin drive
  tmrwo_pin_s next_st;  // Next pin drive

  // Override whenever any mode bit is set, in every waveform mode
  always_comb begin
    next_st.level = (mode_in != COM_OFF) ? obit_in : port_val_in;
    next_st.oe = port_dir_in;
  end

  // Register; costs one cycle of lag but keeps outputs glitch free
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st <= '{level: RST_BIT, oe: RST_BIT};
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  assign pin_out = st.level;
  assign pin_oe_out = st.oe;

endmodule : tmrwo_pin

`default_nettype wire

// ==== tmrwo_port_model.sv ====
// Behavioural model of the port pad that the timer pins drive
`timescale 1ns/1ps
`default_nettype none

module tmrwo_port_model import tmrwo_pkg::*; (
  input wire logic [1:0] pin_in,    // Level offered by the pin driver
  input wire logic [1:0] pin_oe_in, // High while the driver owns the pad
  output wire logic [1:0] pad_out   // Level seen on the pad
);
  // Undriven pad floats to its pull-up, never to the last driven level
  assign pad_out[0] = pin_oe_in[0] ? pin_in[0] : 1'b1;
  assign pad_out[1] = pin_oe_in[1] ? pin_in[1] : 1'b1;
endmodule : tmrwo_port_model
`default_nettype wire

// ==== timer8_waveform_output_test.sv ====
// Self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
`default_nettype none

module timer8_waveform_output_test;
  import tmrwo_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic sys_clk_in, srst_in, clk_en_in, tick_in, cnt_wr, cmp_a_wr, cmp_b_wr;
  logic force_a, force_b, ovf_clr, fa_clr, fb_clr;
  logic [2:0] wgm;
  logic [1:0] com_a, com_b, port_val, port_dir;
  logic [7:0] cnt_wdata, cmp_wdata, cnt, cmp_a, cmp_b;
  logic ovf, flag_a, flag_b, bit_a, bit_b;
  logic [1:0] pin, pin_oe;
  wire logic [1:0] pad; // Resolved pad level
  int n_fail, n_checks, cycles;

  tmrwo_top uut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in), .tick_in(tick_in),
    .waveform_gen_mode_in(wgm), .compare_output_mode_a_in(com_a), .compare_output_mode_b_in(com_b),
    .cnt_wr_in(cnt_wr), .cnt_wdata_in(cnt_wdata), .cmp_a_wr_in(cmp_a_wr), .cmp_b_wr_in(cmp_b_wr),
    .cmp_wdata_in(cmp_wdata), .force_a_in(force_a), .force_b_in(force_b), .ovf_clr_in(ovf_clr),
    .flag_a_clr_in(fa_clr), .flag_b_clr_in(fb_clr), .port_val_in(port_val), .port_dir_in(port_dir),
    .counter_value_out(cnt), .compare_value_a_out(cmp_a), .compare_value_b_out(cmp_b),
    .overflow_flag_out(ovf), .compare_flag_a_out(flag_a), .compare_flag_b_out(flag_b),
    .compare_output_bit_a_out(bit_a), .compare_output_bit_b_out(bit_b), .pin_out(pin), .pin_oe_out(pin_oe));

  tmrwo_port_model port_model (.pin_in(pin), .pin_oe_in(pin_oe), .pad_out(pad));

  // Free-running 125 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // Hang guard: whole run needs well under this many cycles
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Inputs change only at falling edges, away from sampling
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : cyc

  // Compare seen with expected, four-state exact
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  // Short reset between tests, all strobes idle
  task automatic rst();
    srst_in = 1'b1;
    {tick_in, cnt_wr, cmp_a_wr, cmp_b_wr, force_a, force_b, ovf_clr, fa_clr, fb_clr} = '0;
    {wgm, com_a, com_b, port_val, port_dir, cnt_wdata, cmp_wdata} = '0;
    cyc(2);
    srst_in = 1'b0;
    cyc(1);
  endtask : rst

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Normal mode: counter write, wrap and overflow, flag clear
  task automatic t_normal();
    chk({bit_a, bit_b, ovf, flag_a}, 8'h00, "reset state");
    cnt_wr = 1'b1;
    cnt_wdata = 8'hfe;
    tick_in = 1'b1; // Write must win over the tick
    cyc(1);
    cnt_wr = 1'b0;
    chk(cnt, 8'hfe, "counter write");
    cyc(1);
    chk(cnt, 8'hff, "count up");
    chk(ovf, 1'b0, "no early overflow");
    cyc(1);
    chk(cnt, 8'h00, "wrap to zero");
    chk(ovf, 1'b1, "overflow at zero");
    tick_in = 1'b0;
    ovf_clr = 1'b1;
    cyc(1);
    ovf_clr = 1'b0;
    chk(ovf, 1'b0, "overflow cleared");
    $display("test normal done");
  endtask : t_normal

  // Clear-on-match with toggle: period of compare A plus one
  task automatic t_clr_match();
    rst();
    wgm = MODE_CLR_MATCH;
    com_a = COM_TOGGLE;
    cmp_a_wr = 1'b1;
    cmp_wdata = 8'h03;
    cyc(1);
    cmp_a_wr = 1'b0;
    chk(cmp_a, 8'h03, "unbuffered write");
    tick_in = 1'b1;
    cyc(3);
    chk(cnt, 8'h03, "reached top");
    chk(flag_a, 1'b0, "no flag before top");
    cyc(1);
    chk(cnt, 8'h00, "cleared at top");
    chk({flag_a, bit_a}, 8'h03, "flag and toggle");
    cyc(4);
    chk(bit_a, 1'b0, "toggled back");
    $display("test clear-on-match done");
  endtask : t_clr_match

  // Fast PWM, top FF, non-inverting on A with buffered compare
  task automatic t_fast();
    rst();
    wgm = MODE_FAST_MAX;
    com_a = COM_CLEAR;
    cmp_a_wr = 1'b1;
    cmp_wdata = 8'h80;
    cnt_wr = 1'b1;
    cnt_wdata = 8'hfe;
    cyc(1);
    {cmp_a_wr, cnt_wr} = 2'b00;
    tick_in = 1'b1;
    cyc(1);
    chk(cnt, 8'hff, "count held at top");
    chk(cmp_a, 8'h00, "write held in buffer");
    cyc(1);
    chk(cnt, 8'h00, "cleared after top");
    chk(ovf, 1'b1, "overflow at top");
    chk(bit_a, 1'b1, "set at bottom");
    chk(cmp_a, 8'h80, "buffer loaded at top");
    cyc(128);
    chk({flag_a, bit_a}, 8'h01, "high until match");
    cyc(1);
    chk({flag_a, bit_a}, 8'h02, "cleared on match");
    $display("test fast done");
  endtask : t_fast

  // Force in normal mode and pin override through direction
  task automatic t_force_pin();
    rst();
    com_b = COM_SET;
    force_b = 1'b1;
    cmp_b_wr = 1'b1;
    cmp_wdata = 8'h44;
    cyc(1);
    {force_b, cmp_b_wr} = 2'b00;
    chk(bit_b, 1'b1, "forced set");
    chk(flag_b, 1'b0, "force leaves flag");
    chk(cnt, 8'h00, "force leaves counter");
    chk(cmp_b, 8'h44, "compare B written directly");
    cyc(1);
    chk(pin_oe[1], 1'b0, "pin not driven");
    chk(pad[0], 1'b1, "released pad pulled up");
    port_dir = 2'b10;
    cyc(2);
    chk({pin_oe[1], pad[1]}, 8'h03, "compare bit on pad");
    com_b = COM_OFF;
    cyc(2);
    chk(pad[1], 1'b0, "port value back");
    $display("test force done");
  endtask : t_force_pin

  // Counter write suppresses the match on the next tick
  task automatic t_block();
    rst();
    com_a = COM_SET;
    cmp_a_wr = 1'b1;
    cmp_wdata = 8'h10;
    cnt_wr = 1'b1;
    cnt_wdata = 8'h10;
    cyc(1);
    {cmp_a_wr, cnt_wr} = 2'b00;
    cyc(1); // Block survives idle cycles without ticks
    tick_in = 1'b1;
    cyc(1);
    chk({flag_a, bit_a}, 8'h00, "match blocked");
    tick_in = 1'b0;
    cnt_wr = 1'b1;
    cnt_wdata = 8'h10;
    cyc(1);
    cnt_wr = 1'b0;
    tick_in = 1'b1;
    cyc(1);
    chk({flag_a, bit_a}, 8'h00, "match blocked on first tick");
    tick_in = 1'b0;
    cnt_wr = 1'b1;
    cnt_wdata = 8'h0f;
    cyc(1);
    cnt_wr = 1'b0;
    tick_in = 1'b1;
    cyc(2);
    chk({flag_a, bit_a}, 8'h03, "match after block");
    tick_in = 1'b0;
    fa_clr = 1'b1;
    cyc(1);
    fa_clr = 1'b0;
    chk(flag_a, 1'b0, "flag cleared");
    $display("test block done");
  endtask : t_block

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    cycles = 0;
    clk_en_in = 1'b1;
    srst_in = 1'b1;
    {tick_in, cnt_wr, cmp_a_wr, cmp_b_wr, force_a, force_b, ovf_clr, fa_clr, fb_clr} = '0;
    {wgm, com_a, com_b, port_val, port_dir, cnt_wdata, cmp_wdata} = '0;
    cyc(12);
    srst_in = 1'b0;
    cyc(1);
    t_normal();
    t_clr_match();
    t_fast();
    t_force_pin();
    t_block();
    wrap_up();
  end
endmodule : timer8_waveform_output_test
`default_nettype wire
